// ==== dv/adc_external_trigger_sequencer_bench.sv ====
// Self-checking bench for the trigger sequencer
`timescale 1ns/10ps
module adc_external_trigger_sequencer_bench;
    logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, fire = 1'b0, pready, pslverr, err;
    logic        pin, busy, irq;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  width = 4'h1, sel;
    logic [9:0]  sample;
    int          failures = 0, n_checks = 0, n_irq = 0;

    always #2.5 clk = ~clk;
    always @(posedge clk) if (irq === 1'b1) n_irq++;

    adts_top i_dut (.CLK(clk), .SRST(srst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EXT_CONV_TRIGGER_PIN(pin),
        .ADC_SAMPLE(sample), .ANALOG_CHANNEL_SEL(sel),
        .CONV_BUSY_BIT(busy), .CONV_END_IRQ(irq));
    adts_front i_front (.clk(clk), .fire(fire), .width(width),
        .sel(sel), .pin(pin), .sample(sample));

    // ------------
    // Shared tasks
    // ------------
    task automatic conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 64) begin
            failures++;
            conclude();
        end
    endtask : apb
    task automatic cfg(input logic [7:0] b, c, a);
        apb(1'b1, 8'h04, {24'h0, b});
        apb(1'b1, 8'h08, {24'h0, c});
        apb(1'b1, 8'h00, {24'h0, a});
    endtask : cfg
    task automatic trig(input logic [3:0] w);
        @(posedge clk);
        fire <= 1'b1;
        width <= w;
        @(posedge clk);
        fire <= 1'b0;
    endtask : trig
    // Bounded wait for the sequence to finish and the irq to land
    task automatic settle;
        int n = 0;
        repeat (10) @(posedge clk);
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) begin
            failures++;
            conclude();
        end
        repeat (6) @(posedge clk);
    endtask : settle
    task automatic res(input logic [3:0] m, ch);
        apb(1'b0, 8'h40 + {2'h0, m, 2'h0}, 32'h0);
        chk("result", rd, {22'h0, 2'h2, ch, ch});
    endtask : res

    // ------------
    // Scenarios
    // ------------
    task automatic t_sel1;
        int k0;
        k0 = n_irq;
        cfg(8'h01, 8'h01, 8'h01);
        repeat (2) begin
            trig(4'h4);
            repeat (8) @(posedge clk);
            apb(1'b0, 8'h00, 32'h0);
            chk("busy", rd, 32'h3);
            settle();
            res(4'h1, 4'h1);
        end
        chk("irqs", 32'(n_irq - k0), 32'h2);
    endtask : t_sel1
    task automatic t_grp(input logic [7:0] b, a, c, input logic [3:0] w);
        int k0;
        k0 = n_irq;
        cfg(b, c, a);
        trig(w);
        settle();
        chk("irqs", 32'(n_irq - k0), 32'h1);
    endtask : t_grp
    task automatic t_quiet(input logic [7:0] b);
        int k0;
        k0 = n_irq;
        cfg(b, 8'h07, 8'h01);
        trig(4'h4);
        repeat (8) @(posedge clk);
        apb(1'b1, 8'h00, 32'h0);
        settle();
        chk("irqs", 32'(n_irq - k0), 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("fresh 7", {31'h0, rd[7]}, 32'h0);
    endtask : t_quiet

    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("mode reset", rd, 32'h0);
        end
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        t_sel1();
        t_grp(8'h01, 8'h05, 8'h09, 4'h4);
        res(4'h8, 4'h9);
        res(4'h9, 4'h9);
        t_grp(8'h01, 8'h09, 8'h03, 4'h4);
        for (int m = 0; m < 4; m++) res(4'(m), 4'(m));
        t_grp(8'h01, 8'h09, 8'h01, 4'h4);
        res(4'h0, 4'h0);
        t_grp(8'h03, 8'h01, 8'h08, 4'hA);
        res(4'h8, 4'h8);
        t_quiet(8'h00);
        chk("idle", {31'h0, busy}, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        t_quiet(8'h01);
        apb(1'b0, 8'h0C, 32'h0);
        chk("triggers", rd, 32'h8);
        conclude();
    end
endmodule : adc_external_trigger_sequencer_bench

// ==== dv/adts_checker.sv ====
// Port-level assertions for the trigger sequencer
`timescale 1ns/10ps
module adts_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic              CLK,
    input wire logic              SRST,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0]       PWDATA,
    input wire logic [31:0]       PRDATA,
    input wire logic              PREADY,
    input wire logic              PSLVERR,
    input wire logic              EXT_CONV_TRIGGER_PIN,
    input wire logic [3:0]        ANALOG_CHANNEL_SEL,
    input wire logic              CONV_BUSY_BIT,
    input wire logic              CONV_END_IRQ
);
    // ------------
    // Helper history of the trigger pin
    // ------------
    logic [7:0] hist;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    always_ff @(posedge CLK) begin
        hist <= {hist[6:0], EXT_CONV_TRIGGER_PIN};
    end
    // ------------
    // Assertions
    // ------------
    irq_after_busy_a:
        assert property (CONV_END_IRQ |-> !$past(CONV_BUSY_BIT)
            && $past(CONV_BUSY_BIT, 2)) else $error("irq not after busy");
    irq_pulse_a:
        assert property (CONV_END_IRQ |=> !CONV_END_IRQ)
            else $error("irq longer than one cycle");
    busy_cause_a:
        assert property ($rose(CONV_BUSY_BIT) |-> hist != 8'h00
            && hist != 8'hFF) else $error("busy without pin edge");
    chan_range_a:
        assert property (ANALOG_CHANNEL_SEL <= 4'h9)
            else $error("channel out of range");
    stop_clear_a:
        assert property (PSEL && PENABLE && PREADY && PWRITE
            && PADDR == 8'h00 && !PWDATA[0] && CONV_BUSY_BIT
            |-> ##[1:3] !CONV_BUSY_BIT) else $error("stop ignored");
    ready_wait_a:
        assert property (PSEL && PENABLE && !$past(PENABLE)
            |-> !PREADY ##1 PREADY) else $error("ready timing");
    err_with_ready_a:
        assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
            else $error("error without ready");
    unmapped_read_a:
        assert property (PSEL && PENABLE && PREADY && !PWRITE
            && PADDR == 8'h14 |-> PSLVERR && PRDATA == 32'h0)
            else $error("unmapped read answer");
    irq_seen_c: cover property (CONV_END_IRQ);
    busy_seen_c: cover property ($rose(CONV_BUSY_BIT));
    err_seen_c: cover property (PSLVERR);
endmodule : adts_checker

bind adts_top adts_checker #(.ADDR_W(ADDR_W)) i_chk (
    .CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EXT_CONV_TRIGGER_PIN(EXT_CONV_TRIGGER_PIN),
    .ANALOG_CHANNEL_SEL(ANALOG_CHANNEL_SEL),
    .CONV_BUSY_BIT(CONV_BUSY_BIT), .CONV_END_IRQ(CONV_END_IRQ));

// ==== dv/adts_front.sv ====
// Trigger source and analog front end model
`timescale 1ns/10ps
module adts_front (
    input  wire logic       clk,
    input  wire logic       fire,
    input  wire logic [3:0] width,
    input  wire logic [3:0] sel,
    output logic            pin,
    output logic [9:0]      sample
);
    logic [3:0] left;
    initial begin
        pin = 1'b0;
        left = 4'h0;
    end
    // spacing is left to the caller, abort tests need it broken
    always @(posedge clk) begin
        if (fire) begin
            pin <= 1'b1;
            left <= width;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
            if (left == 4'h1) begin
                pin <= 1'b0;
            end
        end
    end
    // Level tied to channel so each stored result is traceable
    assign sample = {2'h2, sel, sel};
endmodule : adts_front

// ==== verilog/adts_conv_timer.sv ====
// Conversion time counter, one done pulse per conversion not stopped or restarted before its end
`timescale 1ns/10ps
module adts_conv_timer #(
    parameter int CNT_W = 12
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             start,
    input  wire logic             stop,
    input  wire logic [CNT_W-1:0] cycles,
    output logic                  done
);
    logic [CNT_W-1:0] cnt;

    // ----------------------------------------------------------------
    // Down counter
    // ----------------------------------------------------------------
    // Restart wins over stop so an abort-and-restart is one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt <= '0;
        end else if (start) begin
            cnt <= cycles;
        end else if (stop) begin
            cnt <= '0;
        end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
        end
    end

    assign done = (cnt == CNT_W'(1)) && !start && !stop;
endmodule : adts_conv_timer

// ==== verilog/adts_defines.svh ====
// Offsets, fields, reset values and timing of the trigger sequencer
//
// Overview of operation
// R1: Enabled, wait edge, run busy, then idle
// R2: Two-bit field selects valid trigger edge
// R3: New trigger mid-conversion restarts from start
// R4: Mode register write mid-conversion restarts
// R5: Select 1-buffer: one conversion, own register
// R6: Select 1-buffer repeats each trigger while enabled
// R7: Select 4-buffer: four conversions, then interrupt
// R8: Four results to consecutive group registers; top group (channels 8-9) keeps only two, later results dropped
// R9: Scan channels zero to last, one interrupt
// R10: After scan, idle; next trigger restarts zero
// R11: Clearing enable stops without storing result
// R12: Source spaces triggers beyond conversion time
// R13: Aborted conversion stores nothing; triggers counted
// R14: Keeps converting and holding registers in HALT
// R15: Result read beats simultaneous result write
// R16: Trigger ignored during result write cycle
// R17: Mode write after store keeps result
// R18: Four-bit channel field picks channel
// R19: Trigger synchronised; edge encoding chosen here
`ifndef ADTS_DEFINES_SVH
`define ADTS_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADTS_OFF_MODE_A    8'h00
`define ADTS_OFF_MODE_B    8'h04
`define ADTS_OFF_MODE_C    8'h08
`define ADTS_OFF_TRIG_CNT  8'h0C
`define ADTS_OFF_FRESH     8'h10
`define ADTS_OFF_RES_BASE  8'h40
`define ADTS_OFF_RES_LAST  8'h64

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define ADTS_A_EN_BIT      0
`define ADTS_A_BUSY_BIT    1
`define ADTS_A_MODE_LSB    2
`define ADTS_A_MODE_MSB    3
`define ADTS_B_EDGE_LSB    0
`define ADTS_B_EDGE_MSB    1
`define ADTS_B_TIME_LSB    4
`define ADTS_B_TIME_MSB    7
`define ADTS_C_CHAN_LSB    0
`define ADTS_C_CHAN_MSB    3
`define ADTS_MODE_A_RST    8'h00
`define ADTS_MODE_B_RST    8'h00
`define ADTS_MODE_C_RST    8'h00
`define ADTS_NUM_RES       10
`define ADTS_LAST_CH       4'h9
`define ADTS_GRP4_LIMIT    4'h4
`define ADTS_GRP8_LIMIT    4'h8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADTS_CLK_NS        5
`define ADTS_CONV_UNIT_NS  100
`define ADTS_CONV_UNIT_CYC \
    ((`ADTS_CONV_UNIT_NS + `ADTS_CLK_NS - 1) / `ADTS_CLK_NS)

`endif

// ==== verilog/adts_pkg.sv ====
// Types shared by the trigger sequencer modules
package adts_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_STORE} adts_state_e;

    typedef enum logic [1:0] {
        MODE_SEL1,
        MODE_SEL4,
        MODE_SCAN,
        MODE_RSVD
    } adts_mode_e;

    typedef enum logic [1:0] {
        EDGE_NONE,
        EDGE_RISE,
        EDGE_FALL,
        EDGE_BOTH
    } adts_edge_e;

endpackage : adts_pkg

// ==== verilog/adts_res_if.sv ====
// Result store port between sequencer and result memory
`timescale 1ns/10ps
interface adts_res_if #(
    parameter int RES_W = 10
);
    logic             we;
    logic [3:0]       waddr;
    logic [RES_W-1:0] wdata;
    logic [3:0]       raddr;
    logic [RES_W-1:0] rdata;

    modport ctl (output we, output waddr, output wdata, output raddr,
                 input rdata);
    modport mem (input we, input waddr, input wdata, input raddr,
                 output rdata);
endinterface : adts_res_if

// ==== verilog/adts_result_mem.sv ====
// Per-channel result registers with registered, read-first output
`timescale 1ns/10ps
`include "adts_defines.svh"
module adts_result_mem #(
    parameter int RES_W = 10,
    parameter int DEPTH = `ADTS_NUM_RES
) (
    input  wire logic clk,
    adts_res_if.mem   port
);
    logic [RES_W-1:0] mem [DEPTH];

    // ----------------------------------------------------------------
    // Store
    // ----------------------------------------------------------------
    // R14 only a store changes a result
    always_ff @(posedge clk) begin
        if (port.we && (int'(port.waddr) < DEPTH)) begin
            mem[port.waddr] <= port.wdata;
        end
    end

    // ----------------------------------------------------------------
    // Read
    // ----------------------------------------------------------------
    // R15 old value served before same-cycle store
    always_ff @(posedge clk) begin
        if (int'(port.raddr) < DEPTH) begin
            port.rdata <= mem[port.raddr];
        end else begin
            port.rdata <= '0;
        end
    end
endmodule : adts_result_mem

// ==== verilog/adts_top.sv ====
// External trigger conversion sequencer with APB register slave
`timescale 1ns/10ps
`include "adts_defines.svh"
module adts_top #(
    parameter int ADDR_W = 8,
    parameter int RES_W  = 10,
    parameter int CNT_W  = 12,
    parameter int TCNT_W = 16
) (
    input  wire logic              CLK,
    input  wire logic              SRST,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire logic              EXT_CONV_TRIGGER_PIN,
    input  wire logic [RES_W-1:0]  ADC_SAMPLE,
    output logic      [3:0]        ANALOG_CHANNEL_SEL,
    output logic                   CONV_BUSY_BIT,
    output logic                   CONV_END_IRQ
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0]               conv_mode_reg_a;
    logic [7:0]               conv_mode_reg_b;
    logic [7:0]               conv_mode_reg_c;
    logic [TCNT_W-1:0]        trig_count;
    logic [`ADTS_NUM_RES-1:0] result_fresh;
    adts_pkg::adts_state_e    state;
    adts_pkg::adts_state_e    next_state;
    logic [3:0]               idx;
    logic [3:0]               next_idx;
    logic                     timer_start;
    logic                     timer_stop;
    logic                     timer_done;
    logic                     store_en;
    logic                     store_last;
    logic                     trig_taken;
    logic                     irq_pend;
    logic                     trg_s1;
    logic                     trg_s2;
    logic                     trg_s3;
    logic                     trig_edge;
    logic                     setup;
    logic                     access_wait;
    logic                     commit_wr;
    logic                     wr_a;
    logic                     wr_b;
    logic                     wr_c;
    logic                     mode_wr;
    logic                     is_res;
    logic [3:0]               res_idx;
    logic [ADDR_W-1:0]        res_off;
    logic                     conv_enable_bit;
    adts_pkg::adts_mode_e     mode;
    adts_pkg::adts_edge_e     trigger_edge_select;
    logic [3:0]               conv_time_sel;
    logic [3:0]               chan;
    logic [3:0]               chan_c;
    logic [3:0]               grp_base;
    logic [3:0]               conv_ch;
    logic [3:0]               store_reg;
    logic                     store_ok;
    logic                     seq_last;
    logic [CNT_W-1:0]         conv_cycles;

    adts_res_if #(.RES_W(RES_W)) res ();

    // ----------------------------------------------------------------
    // Field views
    // ----------------------------------------------------------------
    assign conv_enable_bit = conv_mode_reg_a[`ADTS_A_EN_BIT];
    assign mode = adts_pkg::adts_mode_e'(
        conv_mode_reg_a[`ADTS_A_MODE_MSB:`ADTS_A_MODE_LSB]);
    // R2 edge choice from second mode register
    assign trigger_edge_select = adts_pkg::adts_edge_e'(
        conv_mode_reg_b[`ADTS_B_EDGE_MSB:`ADTS_B_EDGE_LSB]);
    assign conv_time_sel =
        conv_mode_reg_b[`ADTS_B_TIME_MSB:`ADTS_B_TIME_LSB];
    // R18 channel from third mode register
    assign chan = conv_mode_reg_c[`ADTS_C_CHAN_MSB:`ADTS_C_CHAN_LSB];
    // Codes above the last channel fold onto it
    assign chan_c = (chan > `ADTS_LAST_CH) ? `ADTS_LAST_CH : chan;
    // Unit count scaled by field; covers sixteen settings
    assign conv_cycles = CNT_W'((32'(conv_time_sel) + 32'd1) *
                                `ADTS_CONV_UNIT_CYC);

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    assign setup       = PSEL && !PENABLE;
    assign access_wait = PSEL && PENABLE && !PREADY;
    assign commit_wr   = PSEL && PENABLE && PREADY && PWRITE;
    assign wr_a        = commit_wr && (PADDR == `ADTS_OFF_MODE_A);
    assign wr_b        = commit_wr && (PADDR == `ADTS_OFF_MODE_B);
    assign wr_c        = commit_wr && (PADDR == `ADTS_OFF_MODE_C);
    assign mode_wr     = wr_a || wr_b || wr_c;
    assign res_off     = PADDR - `ADTS_OFF_RES_BASE;
    assign is_res      = (PADDR >= `ADTS_OFF_RES_BASE) &&
                         (PADDR <= `ADTS_OFF_RES_LAST) &&
                         (PADDR[1:0] == 2'h0);
    assign res_idx     = res_off[5:2];
    assign res.raddr   = res_idx;

    // One wait state: result memory answers a cycle after setup
    always_ff @(posedge CLK) begin
        if (SRST) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= access_wait;
        end
    end

    // ----------------------------------------------------------------
    // Mode registers
    // ----------------------------------------------------------------
    // R14 held until reset, also through HALT
    always_ff @(posedge CLK) begin
        if (SRST) begin
            conv_mode_reg_a <= `ADTS_MODE_A_RST;
        end else if (wr_a) begin
            conv_mode_reg_a <= PWDATA[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            conv_mode_reg_b <= `ADTS_MODE_B_RST;
        end else if (wr_b) begin
            conv_mode_reg_b <= PWDATA[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            conv_mode_reg_c <= `ADTS_MODE_C_RST;
        end else if (wr_c) begin
            conv_mode_reg_c <= PWDATA[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (access_wait) begin
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            if (is_res) begin
                PRDATA <= 32'(res.rdata);
            end else if (PADDR == `ADTS_OFF_MODE_A) begin
                PRDATA <= {24'h00_0000, conv_mode_reg_a[7:2],
                           CONV_BUSY_BIT, conv_enable_bit};
            end else if (PADDR == `ADTS_OFF_MODE_B) begin
                PRDATA <= {24'h00_0000, conv_mode_reg_b};
            end else if (PADDR == `ADTS_OFF_MODE_C) begin
                PRDATA <= {24'h00_0000, conv_mode_reg_c};
            end else if (PADDR == `ADTS_OFF_TRIG_CNT) begin
                PRDATA <= 32'(trig_count);
            end else if (PADDR == `ADTS_OFF_FRESH) begin
                PRDATA <= 32'(result_fresh);
            end else begin
                PSLVERR <= 1'b1;
            end
        end else begin
            PSLVERR <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Trigger pin
    // ----------------------------------------------------------------
    // R19 two-stage synchroniser, edges seen past it
    always_ff @(posedge CLK) begin
        if (SRST) begin
            trg_s1 <= 1'b0;
            trg_s2 <= 1'b0;
            trg_s3 <= 1'b0;
        end else begin
            trg_s1 <= EXT_CONV_TRIGGER_PIN;
            trg_s2 <= trg_s1;
            trg_s3 <= trg_s2;
        end
    end

    // R2 edge qualification per selected encoding
    always_comb begin
        unique case (trigger_edge_select)
            adts_pkg::EDGE_NONE: trig_edge = 1'b0;
            adts_pkg::EDGE_RISE: trig_edge = trg_s2 && !trg_s3;
            adts_pkg::EDGE_FALL: trig_edge = !trg_s2 && trg_s3;
            adts_pkg::EDGE_BOTH: trig_edge = trg_s2 ^ trg_s3;
        endcase
    end

    // ----------------------------------------------------------------
    // Sequence targets
    // ----------------------------------------------------------------
    always_comb begin
        grp_base  = 4'h0;
        conv_ch   = chan_c;
        store_reg = chan_c;
        store_ok  = 1'b1;
        seq_last  = 1'b1;
        if (chan_c >= `ADTS_GRP8_LIMIT) begin
            grp_base = `ADTS_GRP8_LIMIT;
        end else if (chan_c >= `ADTS_GRP4_LIMIT) begin
            grp_base = `ADTS_GRP4_LIMIT;
        end
        unique case (mode)
            adts_pkg::MODE_SEL4: begin
                // R8 consecutive group registers, first to fourth
                store_reg = grp_base + idx;
                // Top group has two registers; later results dropped
                store_ok  = (store_reg <= `ADTS_LAST_CH);
                // R7 done only after fourth conversion
                seq_last  = (idx == 4'h3);
            end
            adts_pkg::MODE_SCAN: begin
                // R9 channel zero upward, matching register
                conv_ch   = idx;
                store_reg = idx;
                seq_last  = (idx == chan_c);
            end
            adts_pkg::MODE_SEL1, adts_pkg::MODE_RSVD: begin
                // R5 one conversion into own register
                seq_last  = 1'b1;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state  = state;
        next_idx    = idx;
        timer_start = 1'b0;
        timer_stop  = 1'b0;
        store_en    = 1'b0;
        store_last  = 1'b0;
        trig_taken  = 1'b0;
        unique case (state)
            adts_pkg::ST_IDLE: begin
                // R1 R6 R10 each edge starts from index zero
                if (conv_enable_bit && trig_edge) begin
                    trig_taken  = 1'b1;
                    timer_start = 1'b1;
                    next_idx    = 4'h0;
                    next_state  = adts_pkg::ST_CONV;
                end
            end
            adts_pkg::ST_CONV: begin
                if (!conv_enable_bit) begin
                    // R11 abandon, nothing stored
                    timer_stop = 1'b1;
                    next_state = adts_pkg::ST_IDLE;
                end else if (trig_edge || mode_wr) begin
                    // R3 R4 R13 abort and restart, no store
                    trig_taken  = trig_edge;
                    timer_start = 1'b1;
                    next_idx    = 4'h0;
                end else if (timer_done) begin
                    next_state = adts_pkg::ST_STORE;
                end
            end
            adts_pkg::ST_STORE: begin
                // R16 no trigger accepted while storing
                store_en = store_ok;
                if (seq_last) begin
                    // R1 busy drops at sequence end
                    store_last = 1'b1;
                    next_state = adts_pkg::ST_IDLE;
                end else if (!conv_enable_bit) begin
                    next_state = adts_pkg::ST_IDLE;
                end else begin
                    timer_start = 1'b1;
                    next_idx    = mode_wr ? 4'h0 : idx + 4'h1;
                    next_state  = adts_pkg::ST_CONV;
                end
            end
            default: begin
                next_state = adts_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            state <= adts_pkg::ST_IDLE;
            idx   <= 4'h0;
        end else begin
            state <= next_state;
            idx   <= next_idx;
        end
    end

    // R1 busy mirrors the running sequence
    always_ff @(posedge CLK) begin
        if (SRST) begin
            CONV_BUSY_BIT <= 1'b0;
        end else begin
            CONV_BUSY_BIT <= (next_state != adts_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ANALOG_CHANNEL_SEL <= 4'h0;
        end else begin
            ANALOG_CHANNEL_SEL <= conv_ch;
        end
    end

    // R13 every accepted trigger counted, wraps
    always_ff @(posedge CLK) begin
        if (SRST) begin
            trig_count <= '0;
        end else if (trig_taken) begin
            trig_count <= trig_count + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Results and end event
    // ----------------------------------------------------------------
    assign res.we    = store_en;
    assign res.waddr = store_reg;
    assign res.wdata = ADC_SAMPLE;

    // Store sets, result read clears; set wins on a tie
    always_ff @(posedge CLK) begin
        if (SRST) begin
            result_fresh <= '0;
        end else begin
            for (int i = 0; i < `ADTS_NUM_RES; i++) begin
                if (store_en && (store_reg == 4'(i))) begin
                    result_fresh[i] <= 1'b1;
                end else if (setup && is_res && !PWRITE &&
                             (res_idx == 4'(i))) begin
                    result_fresh[i] <= 1'b0;
                end
            end
        end
    end

    // R17 late mode write can swallow the event
    always_ff @(posedge CLK) begin
        if (SRST) begin
            irq_pend     <= 1'b0;
            CONV_END_IRQ <= 1'b0;
        end else begin
            irq_pend     <= store_last;
            CONV_END_IRQ <= irq_pend && !(wr_b || wr_c);
        end
    end

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    adts_conv_timer #(
        .CNT_W (CNT_W)
    ) u_timer (
        .clk    (CLK),
        .srst   (SRST),
        .start  (timer_start),
        .stop   (timer_stop),
        .cycles (conv_cycles),
        .done   (timer_done)
    );

    adts_result_mem #(
        .RES_W (RES_W),
        .DEPTH (`ADTS_NUM_RES)
    ) u_mem (
        .clk  (CLK),
        .port (res.mem)
    );
endmodule : adts_top
